// ==== core/sms_pkg.sv ====
// constants and register map of the system management and debug protection
package sms_pkg;
    // apb register byte offsets
    localparam logic [7:0]  OFS_CLOCK_CFG  = 8'h00;
    localparam logic [7:0]  OFS_MEMPORT    = 8'h04;
    localparam logic [7:0]  OFS_PROT_INFO  = 8'h08;
    localparam logic [7:0]  OFS_RST_STAT   = 8'h0C;
    localparam logic [7:0]  OFS_POWER_CTRL = 8'h10;
    // clock_config_reg fields
    localparam int          DIV_LSB        = 0;
    localparam int          SUB_CLK_BIT    = 7;
    localparam logic [1:0]  DIV_RESET      = 2'h0;
    // reset_source_status fields
    localparam int          RST_STAT_W     = 4;
    localparam int          LOCKUP_EN_BIT  = 4;
    localparam int          DBG_RST_BIT    = 8;
    localparam int          ST_EXT         = 0;
    localparam int          ST_SYS         = 1;
    localparam int          ST_DBG         = 2;
    localparam int          ST_LOCKUP      = 3;
    // protection_info_reg fields
    localparam int          FAIL_LSB       = 2;
    localparam int          SPLIT_LSB      = 16;
    localparam logic [1:0]  PROT_NONE      = 2'h0;
    localparam logic [1:0]  PROT_KEY       = 2'h1;
    localparam logic [1:0]  PROT_PERM      = 2'h2;
    localparam logic [1:0]  MAX_FAILS      = 2'h3;
    // address map seen by the protection filter
    localparam logic [31:0] RAM_BASE       = 32'h2000_0000;
    localparam logic [31:0] RAM_END        = 32'h2000_1FFF;
    localparam logic [31:0] FLASH_BASE     = 32'h0000_0000;
    localparam logic [31:0] FLASH_END      = 32'h0001_7FFF;
    localparam logic [31:0] BOOT_END       = 32'h0000_0FFF;
    localparam logic [31:0] PPB_BASE       = 32'hE000_0000;
    localparam logic [31:0] PPB_END        = 32'hEFFF_FFFF;
    localparam logic [31:0] DEBUG_HALT_CTRL_STATUS_ADDR     = 32'hE000_EDF0;
    localparam int          STEP_BIT       = 2;
    // length of the internal reset pulse in clocks
    localparam logic [2:0]  RST_LEN        = 3'h4;
    localparam logic [2:0]  DIV_CNT_ONE    = 3'h1;
    // power states, one-hot
    typedef enum logic [3:0] {
        PWR_RUN   = 4'b0001,
        PWR_SLEEP = 4'b0010,
        PWR_DEEP  = 4'b0100,
        PWR_DOWN  = 4'b1000
    } sms_pwr_t;
endpackage

// ==== core/sms_top.sv ====
// system management: resets, clock enables, power modes, debug protection
// Function
// RL1 - three failed unlocks make lock permanent
// RL2 - program erase then info erase unlocks
// RL3 - block debug to ram below split
// RL4 - block debug access to main flash
// RL5 - reject cpu flash writes without allow
// RL6 - block debug private region except halt reg
// RL7 - force step bit zero on debug writes
// RL8 - restrict flash commands while protected
// RL9 - status shows protection type and fails
// RL10 - cpu reset request always; debug if unprotected (the debug request here is taken whatever the protection state)
// RL11 - reset register request only from debug
// RL12 - lockup resets only when enabled
// RL13 - external reset spares debug state machine
// RL14 - internal resets keep info, remap, status
// RL15 - debug clock drives access point only
// RL16 - divider defaults to one, selects 1..8
// RL17 - subsystem clock off until enabled
// RL18 - software keeps divider steady when busy
// RL19 - sleep stops core clock only
// RL20 - deep sleep gates clock, companion wake
// RL21 - power-down wfi releases companion select
// RL22 - ram guard low holds ram safe
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module sms_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        dbg_trst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pdebug,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // flash controller events
    input  wire logic        key_lock_cmd,
    input  wire logic        perm_lock_cmd,
    input  wire logic        unlock_fail,
    input  wire logic        unlock_ok,
    input  wire logic        program_section_erase_done,
    input  wire logic        info_erase_done,
    input  wire logic [1:0]  boot_prot_type,
    input  wire logic [1:0]  boot_fail_cnt,
    input  wire logic [15:0] ram_split_boundary,
    input  wire logic        boot_allow,
    input  wire logic        program_section_allow,
    output logic             flash_cmd_restricted,
    // debug port access filter
    input  wire logic        dbg_req,
    input  wire logic        dbg_write,
    input  wire logic [31:0] dbg_addr,
    input  wire logic [31:0] dbg_wdata,
    output logic             dbg_fwd_valid,
    output logic             dbg_fwd_block,
    output logic [31:0]      dbg_fwd_wdata,
    // processor flash write filter
    input  wire logic        cpu_wr,
    input  wire logic [31:0] cpu_addr,
    output logic             cpu_wr_reject,
    // reset sources
    input  wire logic        sys_reset_req,
    input  wire logic        lockup,
    output logic             core_reset_n,
    output logic             dap_reset_n,
    output logic             ram_remap_bit,
    // clocks and power
    input  wire logic        wait_for_irq_instr,
    input  wire logic        deep_sleep_select,
    input  wire logic        enabled_irq,
    input  wire logic        companion_irq_n,
    input  wire logic        companion_irq_en,
    input  wire logic        ram_guard_n,
    output logic             sys_clk_en,
    output logic             core_clk_en,
    output logic             sub_clk_en,
    output logic             companion_cs_release,
    output logic             ram_hold_safe
);
    typedef struct packed {
        logic [1:0]         div;
        logic               sub_en;
        logic               remap;
        logic               loaded;
        logic [1:0]         prot;
        logic [1:0]         fails;
        logic               program_section_erased;
        logic [3:0]         rst_stat;
        logic               lock_en;
        logic               pd_cmd;
        logic [2:0]         div_cnt;
        logic               tick;
        logic [2:0]         rst_cnt;
        logic               rdy;
        logic               err;
        logic [31:0]        rdata;
        logic               fwd_valid;
        logic               fwd_block;
        logic [31:0]        fwd_wdata;
        logic               cpu_rej;
        sms_pkg::sms_pwr_t  pwr;
    } sms_state_t;

    sms_state_t st;
    sms_state_t next_st;
    logic       dap_meta;

    function automatic logic in_range(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic [31:0] split_addr;
    logic        prot_on;
    logic        wr_acc;
    logic        rd_set;
    logic        soft_rst;
    logic        dbg_rst_req;
    logic        lock_rst;
    logic        dbg_blk;
    logic [2:0]  div_len;

    assign split_addr = sms_pkg::RAM_BASE + {14'h0000, ram_split_boundary,
                                             2'h0};
    assign prot_on     = st.prot != sms_pkg::PROT_NONE;
    assign wr_acc      = psel && penable && pwrite && pready;
    assign rd_set      = psel && !penable;
    assign dbg_rst_req = wr_acc && pdebug && paddr[7:0] ==
                         sms_pkg::OFS_RST_STAT &&
                         pwdata[sms_pkg::DBG_RST_BIT]; // RL11
    assign lock_rst    = lockup && st.lock_en; // RL12
    assign soft_rst    = sys_reset_req || dbg_rst_req || lock_rst; // RL10
    assign div_len     = 3'((4'h1 << st.div) - 4'h1);

    // the private region check covers debug port addresses only, not the apb reset register
    always_comb begin
        dbg_blk = 1'b0;
        if (prot_on) begin
            if (in_range(dbg_addr, sms_pkg::RAM_BASE, sms_pkg::RAM_END) &&
                dbg_addr < split_addr) begin
                dbg_blk = 1'b1; // RL3
            end
            if (in_range(dbg_addr, sms_pkg::FLASH_BASE,
                         sms_pkg::FLASH_END)) begin
                dbg_blk = 1'b1; // RL4
            end
            if (in_range(dbg_addr, sms_pkg::PPB_BASE, sms_pkg::PPB_END) &&
                dbg_addr != sms_pkg::DEBUG_HALT_CTRL_STATUS_ADDR) begin
                dbg_blk = 1'b1; // RL6 RL10
            end
        end
    end

    always_comb begin
        next_st = st;
        next_st.rdy = 1'b0;
        // protection state, loaded once after the external reset
        if (!st.loaded) begin
            next_st.loaded = 1'b1;
            next_st.prot   = boot_prot_type;
            next_st.fails  = boot_fail_cnt;
        end else if (perm_lock_cmd) begin
            next_st.prot = sms_pkg::PROT_PERM;
        end else if (key_lock_cmd && st.prot == sms_pkg::PROT_NONE) begin
            next_st.prot = sms_pkg::PROT_KEY;
        end else if (unlock_fail && st.prot == sms_pkg::PROT_KEY) begin
            next_st.fails = st.fails + 2'h1;
            if (st.fails + 2'h1 == sms_pkg::MAX_FAILS) begin
                next_st.prot = sms_pkg::PROT_PERM; // RL1
            end
        end else if (unlock_ok && st.prot == sms_pkg::PROT_KEY) begin
            next_st.prot  = sms_pkg::PROT_NONE;
            next_st.fails = 2'h0;
        end
        if (program_section_erase_done) begin
            next_st.program_section_erased = 1'b1;
        end
        if (info_erase_done && st.program_section_erased) begin
            next_st.prot        = sms_pkg::PROT_NONE; // RL2
            next_st.fails       = 2'h0;
            next_st.program_section_erased = 1'b0;
        end
        // divided system clock enable
        if (st.div_cnt >= div_len) begin
            next_st.div_cnt = 3'h0;
            next_st.tick    = 1'b1; // RL15 RL16
        end else begin
            next_st.div_cnt = st.div_cnt + sms_pkg::DIV_CNT_ONE;
            next_st.tick    = 1'b0;
        end
        // apb: data latched in setup, answered in the first access cycle
        if (rd_set) begin
            next_st.rdy   = 1'b1;
            next_st.err   = 1'b0;
            next_st.rdata = 32'h0000_0000;
            case (paddr[7:0])
                sms_pkg::OFS_CLOCK_CFG: begin
                    next_st.rdata[sms_pkg::DIV_LSB +: 2] = st.div;
                    next_st.rdata[sms_pkg::SUB_CLK_BIT]  = st.sub_en;
                end
                sms_pkg::OFS_MEMPORT: begin
                    next_st.rdata[0] = st.remap;
                end
                sms_pkg::OFS_PROT_INFO: begin
                    next_st.rdata[1:0] = st.prot; // RL9
                    next_st.rdata[sms_pkg::FAIL_LSB +: 2] = st.fails;
                    next_st.rdata[sms_pkg::SPLIT_LSB +: 16] =
                        ram_split_boundary;
                end
                sms_pkg::OFS_RST_STAT: begin
                    next_st.rdata[sms_pkg::RST_STAT_W-1:0] = st.rst_stat;
                    next_st.rdata[sms_pkg::LOCKUP_EN_BIT]  = st.lock_en;
                end
                sms_pkg::OFS_POWER_CTRL: begin
                    next_st.rdata[0] = st.pd_cmd;
                end
                default: begin
                    next_st.err = 1'b1;
                end
            endcase
        end
        if (wr_acc) begin
            case (paddr[7:0])
                sms_pkg::OFS_CLOCK_CFG: begin
                    next_st.div    = pwdata[sms_pkg::DIV_LSB +: 2];
                    next_st.sub_en = pwdata[sms_pkg::SUB_CLK_BIT]; // RL17
                end
                sms_pkg::OFS_MEMPORT: begin
                    next_st.remap = pwdata[0];
                end
                sms_pkg::OFS_RST_STAT: begin
                    next_st.rst_stat = st.rst_stat &
                        ~pwdata[sms_pkg::RST_STAT_W-1:0];
                    next_st.lock_en  = pwdata[sms_pkg::LOCKUP_EN_BIT];
                end
                sms_pkg::OFS_POWER_CTRL: begin
                    next_st.pd_cmd = pwdata[0];
                end
                default: begin
                end
            endcase
        end
        // debug filter, one cycle through
        next_st.fwd_valid = dbg_req;
        next_st.fwd_block = dbg_req && dbg_blk;
        next_st.fwd_wdata = dbg_wdata;
        if (prot_on && dbg_write && dbg_addr == sms_pkg::DEBUG_HALT_CTRL_STATUS_ADDR) begin
            next_st.fwd_wdata[sms_pkg::STEP_BIT] = 1'b0; // RL7
        end
        next_st.cpu_rej = cpu_wr && prot_on &&
            ((in_range(cpu_addr, sms_pkg::FLASH_BASE, sms_pkg::BOOT_END) &&
              !boot_allow) ||
             (in_range(cpu_addr, sms_pkg::BOOT_END + 32'h0000_0001,
                       sms_pkg::FLASH_END) && !program_section_allow)); // RL5
        // power modes
        case (st.pwr)
            sms_pkg::PWR_RUN: begin
                if (wait_for_irq_instr && !deep_sleep_select) begin
                    next_st.pwr = sms_pkg::PWR_SLEEP; // RL19
                end else if (wait_for_irq_instr && st.pd_cmd) begin
                    next_st.pwr = sms_pkg::PWR_DOWN; // RL21
                end else if (wait_for_irq_instr) begin
                    next_st.pwr = sms_pkg::PWR_DEEP; // RL20
                end
            end
            sms_pkg::PWR_SLEEP: begin
                if (enabled_irq) begin
                    next_st.pwr = sms_pkg::PWR_RUN; // RL19
                end
            end
            sms_pkg::PWR_DEEP, sms_pkg::PWR_DOWN: begin
                // only the companion can wake; deep sleep and power-down both return to run this way
                if (!companion_irq_n && companion_irq_en) begin
                    next_st.pwr    = sms_pkg::PWR_RUN; // RL20
                    next_st.pd_cmd = 1'b0;
                end
            end
            default: begin
                next_st.pwr = sms_pkg::PWR_RUN;
            end
        endcase
        // internal reset: protection, remap and status survive
        if (st.rst_cnt != 3'h0) begin
            next_st.rst_cnt = st.rst_cnt - 3'h1;
        end
        if (soft_rst) begin
            next_st.rst_cnt   = sms_pkg::RST_LEN; // RL14
            next_st.div       = sms_pkg::DIV_RESET;
            next_st.sub_en    = 1'b0;
            next_st.lock_en   = 1'b0; // RL12
            next_st.pd_cmd    = 1'b0;
            next_st.pwr       = sms_pkg::PWR_RUN;
            next_st.fwd_valid = 1'b0;
            next_st.cpu_rej   = 1'b0;
        end
        // a new event wins over a clear in the same cycle
        if (sys_reset_req) begin
            next_st.rst_stat[sms_pkg::ST_SYS] = 1'b1;
        end
        if (dbg_rst_req) begin
            next_st.rst_stat[sms_pkg::ST_DBG] = 1'b1;
        end
        if (lock_rst) begin
            next_st.rst_stat[sms_pkg::ST_LOCKUP] = 1'b1;
        end
    end

    // all state but the access point falls to the external reset; protection, remap and status fall to it only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st          <= '0; // RL13
            st.rst_stat <= 4'h1;
            st.pwr      <= sms_pkg::PWR_RUN;
        end else begin
            st <= next_st;
        end
    end

    // the access point state follows its own reset pin, not the system one
    always_ff @(posedge clk or negedge dbg_trst_b) begin
        if (!dbg_trst_b) begin
            dap_meta    <= 1'b0; // RL13
            dap_reset_n <= 1'b0;
        end else begin
            dap_meta    <= 1'b1;
            dap_reset_n <= dap_meta;
        end
    end

    assign pready               = psel && penable && st.rdy;
    assign pslverr              = pready && st.err;
    assign prdata               = st.rdata;
    assign flash_cmd_restricted = prot_on; // RL8
    assign dbg_fwd_valid        = st.fwd_valid;
    assign dbg_fwd_block        = st.fwd_block;
    assign dbg_fwd_wdata        = st.fwd_wdata;
    assign cpu_wr_reject        = st.cpu_rej;
    assign core_reset_n         = st.rst_cnt == 3'h0;
    assign ram_remap_bit        = st.remap;
    assign sys_clk_en           = st.tick &&
                                  !(st.pwr == sms_pkg::PWR_DEEP ||
                                    st.pwr == sms_pkg::PWR_DOWN); // RL20
    assign core_clk_en          = sys_clk_en &&
                                  st.pwr == sms_pkg::PWR_RUN; // RL19
    assign sub_clk_en           = sys_clk_en && st.sub_en; // RL17
    assign companion_cs_release = st.pwr == sms_pkg::PWR_DOWN; // RL21
    assign ram_hold_safe        = !ram_guard_n; // RL22

    a_lock_perm: assert property ( // RL1
        @(posedge clk) disable iff (!rst_b)
        st.loaded && unlock_fail && !perm_lock_cmd && !info_erase_done &&
        st.prot == sms_pkg::PROT_KEY && st.fails == 2'h2
        |=> st.prot == sms_pkg::PROT_PERM && flash_cmd_restricted)
        else $error("third failed unlock did not lock permanently");
    a_erase_unlock: assert property ( // RL2
        @(posedge clk) disable iff (!rst_b)
        st.loaded && info_erase_done && st.program_section_erased
        |=> !flash_cmd_restricted)
        else $error("erase sequence did not remove protection");
    a_ram_block: assert property ( // RL3
        @(posedge clk) disable iff (!rst_b)
        dbg_req && prot_on && !soft_rst &&
        in_range(dbg_addr, sms_pkg::RAM_BASE, sms_pkg::RAM_END)
        |=> dbg_fwd_valid && dbg_fwd_block == ($past(dbg_addr) < split_addr))
        else $error("ram split filtering wrong");
    a_flash_block: assert property ( // RL4
        @(posedge clk) disable iff (!rst_b)
        dbg_req && prot_on && !soft_rst &&
        in_range(dbg_addr, sms_pkg::FLASH_BASE, sms_pkg::FLASH_END)
        |=> dbg_fwd_block)
        else $error("debug flash access not blocked");
    a_cpu_reject: assert property ( // RL5
        @(posedge clk) disable iff (!rst_b)
        cpu_wr && !prot_on && !soft_rst |=> !cpu_wr_reject)
        else $error("cpu write rejected while unprotected");
    a_ppb_block: assert property ( // RL6
        @(posedge clk) disable iff (!rst_b)
        dbg_req && prot_on && !soft_rst && dbg_addr[31:28] == 4'hE
        |=> dbg_fwd_block == ($past(dbg_addr) != sms_pkg::DEBUG_HALT_CTRL_STATUS_ADDR))
        else $error("private region filtering wrong");
    a_step_zero: assert property ( // RL7
        @(posedge clk) disable iff (!rst_b)
        dbg_req && dbg_write && prot_on &&
        dbg_addr == sms_pkg::DEBUG_HALT_CTRL_STATUS_ADDR
        |=> !dbg_fwd_wdata[sms_pkg::STEP_BIT])
        else $error("step bit passed while protected");
    a_lockup_gate: assert property ( // RL12
        @(posedge clk) disable iff (!rst_b)
        lockup && !st.lock_en && !sys_reset_req && !dbg_rst_req &&
        core_reset_n |=> core_reset_n)
        else $error("lockup reset while source disabled");
    a_pd_release: assert property ( // RL21
        @(posedge clk) disable iff (!rst_b)
        st.pwr == sms_pkg::PWR_RUN && wait_for_irq_instr &&
        deep_sleep_select && st.pd_cmd && !soft_rst
        |=> companion_cs_release && !core_clk_en)
        else $error("power-down wfi did not release select");
endmodule
`default_nettype wire

// ==== test/sms_companion.sv ====
// supply companion model: power-down on released select, wake interrupt
`timescale 1ns/1ns
`default_nettype none
module sms_companion (
    input  wire logic clk,
    input  wire logic cs_release,
    input  wire logic wake,
    output logic      irq_n,
    output logic      guard_n
);
    logic [1:0] hold;
    initial begin
        irq_n = 1'b1;
        guard_n = 1'b1;
        hold = 2'h0;
    end
    // once powered down only a wake request brings power and clock back
    always @(posedge clk) begin
        if (wake) begin
            guard_n <= 1'b1;
            irq_n <= 1'b0;
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
            irq_n <= (hold == 2'h1);
        end else if (cs_release) begin
            guard_n <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== test/sms_top_tb.sv ====
// self-checking bench for the system management and protection block
`timescale 1ns/1ns
`default_nettype none
module sms_top_tb;
    logic        clk = 1'b0, rst_b = 1'b0, dbg_trst_b = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pdebug = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, dbg_addr = 32'h0;
    logic [31:0] dbg_wdata = 32'h0, cpu_addr = 32'h0, split, tbl [7];
    logic [1:0]  boot_prot_type = 2'h0, boot_fail_cnt = 2'h0;
    logic [15:0] ram_split_boundary;
    logic        boot_allow = 1'b0, program_section_allow = 1'b0, dbg_req = 1'b0;
    logic        dbg_write = 1'b0, cpu_wr = 1'b0, lockup = 1'b0;
    logic        deep_sleep_select = 1'b0, enabled_irq = 1'b0;
    logic        companion_irq_en = 1'b0;
    logic [8:0]  ev = 9'h0;
    logic [64:0] q [$];
    logic [32:0] qd [$];
    int          seed = 32'hdaf7_6856, mismatches = 0, n_checks = 0, cyc = 0;
    wire logic   key_lock_cmd, perm_lock_cmd, unlock_fail, unlock_ok;
    wire logic   program_section_erase_done, info_erase_done, sys_reset_req;
    wire logic   wait_for_irq_instr, wake, companion_irq_n, ram_guard_n;
    wire logic   pready, pslverr, flash_cmd_restricted, dbg_fwd_valid;
    wire logic   dbg_fwd_block, cpu_wr_reject, core_reset_n, dap_reset_n;
    wire logic   ram_remap_bit, sys_clk_en, core_clk_en, sub_clk_en;
    wire logic   companion_cs_release, ram_hold_safe;
    wire logic [31:0] prdata, dbg_fwd_wdata;
    assign {wake, wait_for_irq_instr, sys_reset_req, info_erase_done,
            program_section_erase_done, unlock_ok, unlock_fail, perm_lock_cmd,
            key_lock_cmd} = ev;
    sms_top dut (.*);
    sms_companion sb (.clk(clk), .cs_release(companion_cs_release),
                      .wake(wake), .irq_n(companion_irq_n),
                      .guard_n(ram_guard_n));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk1(input string nm, input logic seen, exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic finish_test();
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, g, input logic [31:0] a, d, m,
                       input logic e);
        q.push_back({e, m, d});
        @(posedge clk);
        {psel, penable, pwrite, pdebug} <= {2'b10, w, g};
        {paddr, pwdata} <= {a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [31:0] a, d, input logic g);
        apb(1'b1, g, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a, e, m, input logic err);
        apb(1'b0, 1'b0, a, e, m, err);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 9'h1 << i;
        @(posedge clk);
        ev <= 9'h0;
    endtask
    function automatic logic [31:0] info(input logic [1:0] f, t);
        return {ram_split_boundary, 12'h0, f, t};
    endfunction
    task automatic gap(input int e, input logic s);
        int n;
        repeat (2) begin
            n = 0;
            do @(posedge clk); while (sys_clk_en !== 1'b1);
            do begin
                @(posedge clk);
                n++;
            end while (sys_clk_en !== 1'b1 && n < 20);
        end
        check("tick_gap", 32'(n), 32'(e));
        chk1("sub_clk", sub_clk_en, s);
    endtask
    task automatic rst_len(input int e);
        int n;
        n = 0;
        repeat (10) begin
            @(posedge clk);
            n += int'(core_reset_n === 1'b0);
        end
        check("reset_len", 32'(n), 32'(e));
    endtask
    task automatic cpu(input logic [31:0] a, input logic e);
        @(posedge clk);
        {cpu_wr, cpu_addr} <= {1'b1, a};
        @(posedge clk);
        cpu_wr <= 1'b0;
        @(posedge clk);
        chk1("cpu_reject", cpu_wr_reject, e);
    endtask
    task automatic filt(input logic p);
        logic [31:0] d;
        logic [31:0] e;
        for (int i = 0; i < 7; i++) begin
            d = $random(seed) | 32'h0000_0004;
            e = (p && i == 4) ? d & ~(32'h1 << sms_pkg::STEP_BIT) : d;
            qd.push_back({p & 1'(7'b0101101 >> i), e});
            @(posedge clk);
            {dbg_req, dbg_write, dbg_addr, dbg_wdata} <= {2'b11, tbl[i], d};
            @(posedge clk);
            dbg_req <= 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            {boot_allow, program_section_allow} <= 2'(i);
            cpu(32'h0000_0100, p & !i[1]);
            cpu(32'h0000_2000, p & !i[0]);
        end
        chk1("cmd_restrict", flash_cmd_restricted, p);
    endtask
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            check("pslverr", {31'h0, pslverr}, {31'h0, q[0][64]});
            check("prdata", prdata & q[0][63:32], q[0][31:0] & q[0][63:32]);
            void'(q.pop_front());
        end
        if (dbg_fwd_valid === 1'b1) begin
            chk1("fwd_block", dbg_fwd_block, qd[0][32]);
            if (!qd[0][32]) check("fwd_wdata", dbg_fwd_wdata, qd[0][31:0]);
            void'(qd.pop_front());
        end
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        ram_split_boundary = 16'h0001 + (16'($random(seed)) & 16'h07FE);
        split = 32'h2000_0000 + {14'h0, ram_split_boundary, 2'b00};
        tbl = '{split - 32'h4, split, sms_pkg::FLASH_END - 32'h3,
                32'hE000_E000, sms_pkg::DEBUG_HALT_CTRL_STATUS_ADDR,
                sms_pkg::PPB_END - 32'h3, 32'h4000_0000};
        repeat (5) @(posedge clk);
        {rst_b, dbg_trst_b} <= 2'b11;
        repeat (2) @(posedge clk);
        rd(32'h0C, 32'h1, 32'h1F, 1'b0);
        rd(32'h00, 32'h0, 32'hFF, 1'b0);
        rd(32'h14, 32'h0, 32'h0, 1'b1);
        gap(1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wr(32'h00, {24'h0, k[0], 5'h0, k[1:0]}, 1'b0);
            gap(1 << k, k[0]);
        end
        pulse(0);
        rd(32'h08, info(2'h0, 2'h1), 32'hFFFF_000F, 1'b0);
        filt(1'b1);
        pulse(2);
        pulse(2);
        rd(32'h08, info(2'h2, 2'h1), 32'hFFFF_000F, 1'b0);
        pulse(2);
        rd(32'h08, info(2'h3, 2'h2), 32'hFFFF_000F, 1'b0);
        pulse(4);
        pulse(5);
        rd(32'h08, 32'h0, 32'h3, 1'b0);
        filt(1'b0);
        pulse(1);
        rd(32'h08, 32'h2, 32'h3, 1'b0);
        pulse(4);
        pulse(5);
        rd(32'h08, 32'h0, 32'h3, 1'b0);
        wr(32'h04, 32'h1, 1'b0);
        wr(32'h0C, 32'h100, 1'b0);
        rst_len(0);
        wr(32'h0C, 32'h100, 1'b1);
        rst_len(4);
        lockup <= 1'b1;
        rst_len(0);
        wr(32'h0C, 32'h10, 1'b0);
        rst_len(4);
        rst_len(0);
        lockup <= 1'b0;
        rd(32'h0C, 32'hD, 32'h1F, 1'b0);
        rd(32'h04, 32'h1, 32'h1, 1'b0);
        chk1("remap", ram_remap_bit, 1'b1);
        pulse(6);
        rst_len(4);
        rd(32'h0C, 32'h2, 32'h2, 1'b0);
        pulse(7);
        repeat (3) @(posedge clk);
        chk1("core_clk", core_clk_en, 1'b0);
        chk1("sys_clk", sys_clk_en, 1'b1);
        enabled_irq <= 1'b1;
        repeat (3) @(posedge clk);
        chk1("core_clk", core_clk_en, 1'b1);
        {enabled_irq, deep_sleep_select} <= 2'b01;
        pulse(7);
        pulse(8);
        repeat (6) @(posedge clk);
        chk1("sys_clk", sys_clk_en, 1'b0);
        companion_irq_en <= 1'b1;
        pulse(8);
        repeat (6) @(posedge clk);
        chk1("sys_clk", sys_clk_en, 1'b1);
        wr(32'h10, 32'h1, 1'b0);
        pulse(7);
        repeat (3) @(posedge clk);
        chk1("cs_release", companion_cs_release, 1'b1);
        chk1("ram_safe", ram_hold_safe, 1'b1);
        {boot_prot_type, boot_fail_cnt, rst_b} <= {sms_pkg::PROT_PERM, 3'h6};
        repeat (2) @(posedge clk);
        chk1("dap_reset", dap_reset_n, 1'b1);
        pulse(8);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rd(32'h10, 32'h0, 32'h1, 1'b0);
        rd(32'h08, info(2'h3, 2'h2), 32'hFFFF_000F, 1'b0);
        chk1("cs_release", companion_cs_release, 1'b0);
        dbg_trst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk1("dap_reset", dap_reset_n, 1'b0);
        dbg_trst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk1("dap_reset", dap_reset_n, 1'b1);
        check("queues", q.size() + qd.size(), 0);
        finish_test();
    end
endmodule
`default_nettype wire
